// ==== src/bsx_pkg.sv ====
// Shared constants and carrier types for the branch and skip unit.
package bsx_pkg;

	// ****************************************
	// Operation codes and augment codes
	// ****************************************
	localparam logic [3:0] OP_AUG = 4'h0; // Augmented zero group
	localparam logic [3:0] OP_JUMP = 4'h9; // Octal 11
	localparam logic [3:0] OP_SAVE = 4'hA; // Octal 12
	localparam logic [3:0] OP_SENSE = 4'hB; // Octal 13
	localparam logic [3:0] OP_BUMPM = 4'hC; // Octal 14
	localparam logic [3:0] OP_CMP = 4'hD; // Octal 15
	localparam logic [7:0] SENSE_AUG = 8'h10; // Bits 4 to 11 of 1304
	localparam logic [5:0] AUG_SIGN3 = 6'h11; // Octal 21
	localparam logic [5:0] AUG_ZERO = 6'h12; // Octal 22
	localparam logic [5:0] AUG_NEG = 6'h13; // Octal 23
	localparam logic [5:0] AUG_POS = 6'h14; // Octal 24
	localparam logic [5:0] AUG_NOOVF = 6'h15; // Octal 25
	localparam logic [5:0] AUG_BUMPB = 6'h16; // Octal 26
	localparam logic [5:0] AUG_NORM = 6'h1A; // Octal 32
	localparam logic [5:0] AUG_LONG = 6'h1E; // Octal 36
	localparam logic [5:0] AUG_PTRB = 6'h28; // Octal 50
	localparam logic [5:0] AUG_BUMPX = 6'h29; // Octal 51

	// ****************************************
	// Program counter advances
	// ****************************************
	localparam logic [1:0] ADV_NEXT = 2'h1; // Following instruction
	localparam logic [1:0] ADV_SKIP = 2'h2; // Skip one word
	localparam logic [1:0] ADV_SKIP2 = 2'h3; // Skip two words
	localparam logic [14:0] PC_ONE = 15'h0001; // Plus one step

	// ****************************************
	// Register map and field positions
	// ****************************************
	localparam logic [3:0] REG_CTRL = 4'h0; // Control, read/write
	localparam logic [3:0] REG_STATUS = 4'h4; // Status, read only
	localparam logic [3:0] REG_PC = 4'h8; // Program counter
	localparam int CTRL_PROT_MODE = 0; // Protect mode switch
	localparam int CTRL_PTR_B = 1; // Index pointer on B
	localparam int CTRL_OVF_SET = 2; // Write one sets overflow
	localparam int CTRL_OVF_CLR = 3; // Write one clears overflow
	localparam int STAT_OVF = 0; // Overflow latch
	localparam int STAT_PROT = 1; // Protect latch
	localparam int STAT_BUSY = 2; // Instruction in progress
	localparam logic [31:0] WB_ZERO = 32'h0000_0000; // Idle read data

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, // Waiting for an instruction
		S_FETCH2 = 3'b001, // Second word of long jump
		S_STORE = 3'b010, // Return word write
		S_READ = 3'b011, // Operand read
		S_WRITE = 3'b100, // Incremented word write
		S_EVAL = 3'b101, // Signed compare
		S_HOLD = 3'b110 // Extra cycle of a taken index skip
	} bsx_fsm_t;

	typedef struct packed {
		logic valid; // Instruction offered
		logic [15:0] instr; // Instruction word
		logic [15:0] ea; // Effective address, bit 15 is bit 0
		logic [15:0] a; // Accumulator A
		logic [15:0] b; // Accumulator B
		logic [15:0] x; // Index register
		logic indirect; // Indirect flag of the instruction
		logic by_irq; // Forced by a priority interrupt
		logic after_exit; // Follows interrupt_exit_prefix
	} bsx_issue_t;

	typedef struct packed {
		logic req; // Memory cycle requested
		logic we; // Write when high
		logic [14:0] addr; // Word address
		logic [15:0] wdata; // Write data
	} bsx_mem_t;

	typedef struct packed {
		logic done; // One-cycle completion pulse
		logic [15:0] b; // New accumulator B
		logic b_we; // B is to be updated
		logic [15:0] x; // New index register
		logic x_we; // X is to be updated
	} bsx_result_t;

endpackage

// ==== src/bsx_unit.sv ====
// Branch and skip execution unit with its Wishbone register slave.
//
// Overview of operation
// - Jump loads effective address, one cycle
// - Protected exit jump: bits 2-15, latch
// - Save return: store PC+1, jump EA+1
// - Interrupt save stores PC without increment
// - Interrupt indirect save stores protect latch
// - Bump memory, write back, skip zero
// - Signed compare, equal skips one, three cycles
// - Panel switch clear skips next instruction
// - Bump B, skip when nonnegative
// - Sign skip: negative, zero, positive ways
// - Skip when A is zero
// - Skip when A is negative
// - Skip when A is nonnegative
// - Overflow set: clear, no skip; else skip
// - Skip when A bits 1 and 0 differ
// - Long jump loads second word bits 1-15
// - Protected exit long jump loads protect latch from bit 0
// - Skip when index pointer selects B
// - Add count to index, skip nonnegative
// - Zero count only tests index register
// - Skip bypasses one word, double two
`timescale 1ns/10ps

module bsx_unit (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire bsx_pkg::bsx_issue_t issue_i,
	output logic busy_o,
	output bsx_pkg::bsx_result_t res_o,
	output bsx_pkg::bsx_mem_t mem_o,
	input wire logic mem_ack_i,
	input wire logic [15:0] mem_rdata_i,
	input wire logic [15:0] switch_i,
	input wire logic ovf_set_i,
	output logic [14:0] pc_o,
	output logic ovf_o,
	output logic prot_o,
	output logic ptr_b_o
);

	// ****************************************
	// State of the unit
	// ****************************************
	typedef struct packed {
		bsx_pkg::bsx_fsm_t st; // Sequencer state
		logic busy; // Instruction in progress
		logic [14:0] pc; // Program counter
		logic ovf; // Overflow latch
		logic prot; // Protect latch
		logic prot_mode; // Protect mode switch
		logic ptr_b; // Index pointer selects B
		logic [15:0] sw_meta; // Switch synchroniser, first stage
		logic [15:0] sw_sync; // Switch synchroniser, second stage
		logic [15:0] instr; // Captured instruction
		logic [15:0] ea; // Captured effective address
		logic [15:0] a; // Captured accumulator A
		logic [15:0] opnd; // Memory operand
		logic after_exit; // Captured exit flag
		logic [1:0] adv; // Advance held for the extra cycle
		bsx_pkg::bsx_mem_t mem; // Memory request
		bsx_pkg::bsx_result_t res; // Results to the datapath
		logic wb_ack; // Bus acknowledge
		logic [31:0] wb_dat; // Bus read data
	} bsx_regs_t;

	bsx_regs_t r_q; // Registered state
	bsx_regs_t r_d; // Next state

	// ****************************************
	// Next-state logic
	// ****************************************
	// Bus slave, sequencer and latches share one process so that the
	// priorities between them are visible in a single place.
	always_comb begin
		logic [3:0] op;
		logic [5:0] aug;
		logic [15:0] word;
		logic [15:0] sum;
		logic [1:0] adv;
		logic fin;
		logic step;
		op = issue_i.instr[15:12];
		aug = issue_i.instr[5:0];
		word = 16'h0000;
		sum = 16'h0000;
		adv = bsx_pkg::ADV_NEXT;
		fin = 1'b0;
		step = 1'b0;
		r_d = r_q;
		// Pulses last one cycle only
		r_d.res.done = 1'b0;
		r_d.res.b_we = 1'b0;
		r_d.res.x_we = 1'b0;

		// Panel switches come from outside the clock domain
		r_d.sw_meta = switch_i;
		r_d.sw_sync = r_q.sw_meta;

		// Classic single-cycle answer, dropped the cycle after
		r_d.wb_ack = wb_cyc_i & wb_stb_i & ~r_q.wb_ack;
		r_d.wb_dat = bsx_pkg::WB_ZERO;
		if (r_d.wb_ack) begin
			case (wb_adr_i)
				bsx_pkg::REG_CTRL: begin
					r_d.wb_dat[bsx_pkg::CTRL_PROT_MODE] = r_q.prot_mode;
					r_d.wb_dat[bsx_pkg::CTRL_PTR_B] = r_q.ptr_b;
					if (wb_we_i && wb_sel_i[0]) begin
						r_d.prot_mode = wb_dat_i[bsx_pkg::CTRL_PROT_MODE];
						r_d.ptr_b = wb_dat_i[bsx_pkg::CTRL_PTR_B];
						if (wb_dat_i[bsx_pkg::CTRL_OVF_CLR]) begin
							r_d.ovf = 1'b0;
						end
						if (wb_dat_i[bsx_pkg::CTRL_OVF_SET]) begin
							r_d.ovf = 1'b1;
						end
					end
				end
				bsx_pkg::REG_STATUS: begin
					r_d.wb_dat[bsx_pkg::STAT_OVF] = r_q.ovf;
					r_d.wb_dat[bsx_pkg::STAT_PROT] = r_q.prot;
					r_d.wb_dat[bsx_pkg::STAT_BUSY] = r_q.busy;
				end
				bsx_pkg::REG_PC: begin
					r_d.wb_dat[14:0] = r_q.pc;
					// Writes while busy would race the sequencer
					if (wb_we_i && !r_q.busy) begin
						if (wb_sel_i[0]) begin
							r_d.pc[7:0] = wb_dat_i[7:0];
						end
						if (wb_sel_i[1]) begin
							r_d.pc[14:8] = wb_dat_i[14:8];
						end
					end
				end
				default: begin
					// Unmapped: reads zero, writes dropped
					r_d.wb_dat = bsx_pkg::WB_ZERO;
				end
			endcase
		end

		// Sequencer
		case (r_q.st)
			bsx_pkg::S_IDLE: begin
				if (issue_i.valid && !r_q.busy) begin
					r_d.instr = issue_i.instr;
					r_d.ea = issue_i.ea;
					r_d.a = issue_i.a;
					r_d.after_exit = issue_i.after_exit;
					r_d.res.b = issue_i.b;
					r_d.res.x = issue_i.x;
					r_d.busy = 1'b1;
					case (op)
						bsx_pkg::OP_JUMP: begin
							if (r_q.prot_mode && issue_i.indirect &&
								issue_i.after_exit) begin
								r_d.pc = {1'b0, issue_i.ea[13:0]};
								r_d.prot = issue_i.ea[15];
							end else begin
								r_d.pc = issue_i.ea[14:0];
							end
							fin = 1'b1;
						end
						bsx_pkg::OP_SAVE: begin
							// Interrupt entry keeps the interrupted address
							if (issue_i.by_irq) begin
								word = {1'b0, r_q.pc};
							end else begin
								word = {1'b0, r_q.pc + bsx_pkg::PC_ONE};
							end
							if (issue_i.by_irq && issue_i.indirect &&
								r_q.prot_mode) begin
								word[15] = r_q.prot;
							end
							r_d.mem.req = 1'b1;
							r_d.mem.we = 1'b1;
							r_d.mem.addr = issue_i.ea[14:0];
							r_d.mem.wdata = word;
							r_d.st = bsx_pkg::S_STORE;
						end
						bsx_pkg::OP_BUMPM, bsx_pkg::OP_CMP: begin
							r_d.mem.req = 1'b1;
							r_d.mem.we = 1'b0;
							r_d.mem.addr = issue_i.ea[14:0];
							r_d.st = bsx_pkg::S_READ;
						end
						bsx_pkg::OP_SENSE: begin
							if (issue_i.instr[11:4] == bsx_pkg::SENSE_AUG &&
								!r_q.sw_sync[issue_i.instr[3:0]]) begin
								adv = bsx_pkg::ADV_SKIP;
							end
							step = 1'b1;
							fin = 1'b1;
						end
						bsx_pkg::OP_AUG: begin
							step = 1'b1;
							fin = 1'b1;
							case (aug)
								bsx_pkg::AUG_SIGN3: begin
									if (issue_i.a[15]) begin
										adv = bsx_pkg::ADV_NEXT;
									end else if (issue_i.a == 16'h0000) begin
										adv = bsx_pkg::ADV_SKIP;
									end else begin
										adv = bsx_pkg::ADV_SKIP2;
									end
								end
								bsx_pkg::AUG_ZERO: begin
									if (issue_i.a == 16'h0000) begin
										adv = bsx_pkg::ADV_SKIP;
									end
								end
								bsx_pkg::AUG_NEG: begin
									if (issue_i.a[15]) begin
										adv = bsx_pkg::ADV_SKIP;
									end
								end
								bsx_pkg::AUG_POS: begin
									if (!issue_i.a[15]) begin
										adv = bsx_pkg::ADV_SKIP;
									end
								end
								bsx_pkg::AUG_NOOVF: begin
									if (r_q.ovf) begin
										r_d.ovf = 1'b0;
									end else begin
										adv = bsx_pkg::ADV_SKIP;
									end
								end
								bsx_pkg::AUG_BUMPB: begin
									sum = issue_i.b + 16'h0001;
									r_d.res.b = sum;
									r_d.res.b_we = 1'b1;
									if (!sum[15]) begin
										adv = bsx_pkg::ADV_SKIP;
									end
								end
								bsx_pkg::AUG_NORM: begin
									if (issue_i.a[14] != issue_i.a[15]) begin
										adv = bsx_pkg::ADV_SKIP;
									end
								end
								bsx_pkg::AUG_LONG: begin
									// Second word sits right after this one
									step = 1'b0;
									fin = 1'b0;
									r_d.mem.req = 1'b1;
									r_d.mem.we = 1'b0;
									r_d.mem.addr = r_q.pc + bsx_pkg::PC_ONE;
									r_d.st = bsx_pkg::S_FETCH2;
								end
								bsx_pkg::AUG_PTRB: begin
									if (r_q.ptr_b) begin
										adv = bsx_pkg::ADV_SKIP;
									end
								end
								bsx_pkg::AUG_BUMPX: begin
									sum = issue_i.x + {12'h000, issue_i.instr[9:6]};
									// Zero count keeps index; strobe rides done
									if (issue_i.instr[9:6] != 4'h0) begin
										r_d.res.x = sum;
										r_d.res.x_we = sum[15];
									end
									if (!sum[15]) begin
										step = 1'b0;
										fin = 1'b0;
										r_d.adv = bsx_pkg::ADV_SKIP;
										r_d.st = bsx_pkg::S_HOLD;
									end
								end
								default: begin
									// Outside this group: just move on
									adv = bsx_pkg::ADV_NEXT;
								end
							endcase
						end
						default: begin
							// Other groups are not executed here
							step = 1'b1;
							fin = 1'b1;
						end
					endcase
				end
			end
			bsx_pkg::S_STORE: begin
				if (mem_ack_i) begin
					r_d.mem.req = 1'b0;
					r_d.pc = r_q.ea[14:0] + bsx_pkg::PC_ONE;
					fin = 1'b1;
				end
			end
			bsx_pkg::S_FETCH2: begin
				if (mem_ack_i) begin
					r_d.mem.req = 1'b0;
					r_d.pc = mem_rdata_i[14:0];
					if (r_q.prot_mode && r_q.after_exit) begin
						r_d.prot = mem_rdata_i[15];
					end
					fin = 1'b1;
				end
			end
			bsx_pkg::S_READ: begin
				if (mem_ack_i) begin
					r_d.opnd = mem_rdata_i;
					if (r_q.instr[15:12] == bsx_pkg::OP_BUMPM) begin
						r_d.mem.we = 1'b1;
						r_d.mem.wdata = mem_rdata_i + 16'h0001;
						r_d.st = bsx_pkg::S_WRITE;
					end else begin
						r_d.mem.req = 1'b0;
						r_d.st = bsx_pkg::S_EVAL;
					end
				end
			end
			bsx_pkg::S_WRITE: begin
				if (mem_ack_i) begin
					r_d.mem.req = 1'b0;
					if (r_q.mem.wdata == 16'h0000) begin
						adv = bsx_pkg::ADV_SKIP;
					end
					step = 1'b1;
					fin = 1'b1;
				end
			end
			bsx_pkg::S_EVAL: begin
				// Neither operand is written back
				if ($signed(r_q.a) < $signed(r_q.opnd)) begin
					adv = bsx_pkg::ADV_NEXT;
				end else if (r_q.a == r_q.opnd) begin
					adv = bsx_pkg::ADV_SKIP;
				end else begin
					adv = bsx_pkg::ADV_SKIP2;
				end
				step = 1'b1;
				fin = 1'b1;
			end
			bsx_pkg::S_HOLD: begin
				adv = r_q.adv;
				r_d.res.x_we = r_q.instr[9:6] != 4'h0;
				step = 1'b1;
				fin = 1'b1;
			end
			default: begin
				// Unused code: recover to idle
				fin = 1'b1;
			end
		endcase

		// Advance by one, two or three words
		if (step) begin
			r_d.pc = r_q.pc + {13'h0000, adv};
		end
		if (fin) begin
			r_d.res.done = 1'b1;
			r_d.busy = 1'b0;
			r_d.st = bsx_pkg::S_IDLE;
		end

		// Hardware overflow wins over any clear in the same cycle
		if (ovf_set_i) begin
			r_d.ovf = 1'b1;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// Synchronous reset to all zeros: idle, not busy, latches clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	// ****************************************
	// Outputs, straight from flip-flops
	// ****************************************
	assign wb_dat_o = r_q.wb_dat;
	assign wb_ack_o = r_q.wb_ack;
	assign busy_o = r_q.busy;
	assign res_o = r_q.res;
	assign mem_o = r_q.mem;
	assign pc_o = r_q.pc;
	assign ovf_o = r_q.ovf;
	assign prot_o = r_q.prot;
	assign ptr_b_o = r_q.ptr_b;

endmodule

// ==== testbench/bsx_unit_asserts.sv ====
// Concurrent checks on the ports of the branch and skip unit.
`timescale 1ns/10ps

module bsx_unit_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire bsx_pkg::bsx_issue_t issue_i,
	input wire logic busy_o,
	input wire bsx_pkg::bsx_result_t res_o,
	input wire bsx_pkg::bsx_mem_t mem_o,
	input wire logic mem_ack_i,
	input wire logic [14:0] pc_o,
	input wire logic ovf_o,
	input wire logic ovf_set_i
);
	// ****************************************
	// Helper decode of the offered instruction
	// ****************************************
	logic take; // Issue accepted at this edge
	logic aug; // Plain augmented word accepted
	logic [5:0] code; // Augment code field
	logic [15:0] xsum; // Index plus count field
	assign take = issue_i.valid && !busy_o;
	assign aug = take && issue_i.instr[15:6] == 10'h000;
	assign code = issue_i.instr[5:0];
	assign xsum = issue_i.x + {12'h000, issue_i.instr[9:6]};

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ****************************************
	// Assertions
	// ****************************************
	jump_target_a: assert property (take && !issue_i.after_exit
		&& issue_i.instr[15:12] == bsx_pkg::OP_JUMP |=> res_o.done
		&& pc_o == $past(issue_i.ea[14:0])) else $error("jump target wrong");
	zero_skip_a: assert property (aug && code == bsx_pkg::AUG_ZERO |=>
		res_o.done && pc_o == $past(pc_o) + (($past(issue_i.a) == 16'h0000)
		? 15'h0002 : 15'h0001)) else $error("zero skip wrong");
	neg_skip_a: assert property (aug && code == bsx_pkg::AUG_NEG |=>
		pc_o == $past(pc_o) + ($past(issue_i.a[15]) ? 15'h0002 : 15'h0001))
		else $error("negative skip wrong");
	pos_skip_a: assert property (aug && code == bsx_pkg::AUG_POS |=>
		pc_o == $past(pc_o) + ($past(issue_i.a[15]) ? 15'h0001 : 15'h0002))
		else $error("positive skip wrong");
	sign_three_a: assert property (aug && code == bsx_pkg::AUG_SIGN3 |=>
		pc_o == $past(pc_o) + ($past(issue_i.a[15]) ? 15'h0001 :
		(($past(issue_i.a) == 16'h0000) ? 15'h0002 : 15'h0003)))
		else $error("sign skip wrong");
	// Normalised means sign and next bit differ
	norm_skip_a: assert property (aug && code == bsx_pkg::AUG_NORM |=>
		pc_o == $past(pc_o) + (($past(issue_i.a[15]) != $past(issue_i.a[14]))
		? 15'h0002 : 15'h0001)) else $error("normalised skip wrong");
	ovf_clear_a: assert property (aug && code == bsx_pkg::AUG_NOOVF
		&& ovf_o && !ovf_set_i |=> !ovf_o && pc_o == $past(pc_o) + 15'h0001)
		else $error("overflow test wrong");
	bump_b_a: assert property (aug && code == bsx_pkg::AUG_BUMPB |=>
		res_o.b_we && res_o.b == $past(issue_i.b) + 16'h0001)
		else $error("bump b wrong");
	save_word_a: assert property (take && !issue_i.by_irq
		&& issue_i.instr[15:12] == bsx_pkg::OP_SAVE |=> mem_o.req && mem_o.we
		&& mem_o.wdata[14:0] == $past(pc_o) + 15'h0001) else $error("save word");
	irq_save_a: assert property (take && issue_i.by_irq
		&& issue_i.instr[15:12] == bsx_pkg::OP_SAVE |=> mem_o.req
		&& mem_o.wdata[14:0] == $past(pc_o)) else $error("irq save word");
	// A taken index skip costs one extra cycle
	index_skip_a: assert property (take && issue_i.instr[15:10] == 6'h00
		&& code == bsx_pkg::AUG_BUMPX && !xsum[15] |=> !res_o.done ##1
		res_o.done) else $error("index skip timing");
	mem_hold_a: assert property (mem_o.req && !mem_ack_i |=> mem_o.req
		&& $stable(mem_o.addr) && $stable(mem_o.we)) else $error("mem dropped");
	bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
		wb_ack_o ##1 !wb_ack_o) else $error("bus ack not one pulse");
endmodule

bind bsx_unit bsx_unit_chk bsx_unit_chk_i (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.issue_i(issue_i), .busy_o(busy_o), .res_o(res_o), .mem_o(mem_o),
	.mem_ack_i(mem_ack_i), .pc_o(pc_o), .ovf_o(ovf_o), .ovf_set_i(ovf_set_i));

// ==== testbench/bsx_core_mem.sv ====
// Behavioural core memory answering the unit's memory port.
`timescale 1ns/10ps

module bsx_core_mem (
	input wire logic clk_i,
	input wire bsx_pkg::bsx_mem_t mem_i,
	input wire logic [3:0] lat_i,
	output logic ack_o,
	output logic [15:0] rdata_o
);
	logic [15:0] mem [0:255]; // Small window of core words
	logic [3:0] cnt_q = 4'h0; // Cycles waited on this request
	logic [15:0] last_q = 16'h0000; // Last value on the data lines
	// Answer after lat_i waiting cycles; zero answers in the request cycle
	assign ack_o = mem_i.req && cnt_q == lat_i;
	// Outside an answer the lines toggle so stale data never looks valid
	assign rdata_o = (ack_o && !mem_i.we) ? mem[mem_i.addr[7:0]] : ~last_q;
	// ****************************************
	// Cycle counting and write-back
	// ****************************************
	always @(posedge clk_i) begin
		last_q <= rdata_o;
		if (ack_o) begin
			cnt_q <= 4'h0;
		end else if (mem_i.req) begin
			cnt_q <= cnt_q + 4'h1;
		end
		if (ack_o && mem_i.we) begin
			mem[mem_i.addr[7:0]] <= mem_i.wdata;
		end
	end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the branch and skip unit.
`timescale 1ns/10ps

module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, wb_ack_o, busy_o, mem_ack, ovf_o, prot_o, ptr_b_o;
	logic ovf_set;
	logic [3:0] adr, lat;
	logic [31:0] dat, rd, wb_dat_o;
	logic [15:0] rdata, sw, s;
	logic [14:0] pc_o;
	bsx_pkg::bsx_issue_t iss;
	bsx_pkg::bsx_result_t res_o, got;
	bsx_pkg::bsx_mem_t mem_o;
	int err_total, total_checks, ncyc, i, j, lt;
	logic [5:0] ops [5] = '{bsx_pkg::AUG_SIGN3, bsx_pkg::AUG_ZERO,
		bsx_pkg::AUG_NEG, bsx_pkg::AUG_POS, bsx_pkg::AUG_NORM};
	logic [15:0] av [5] = '{16'h0000, 16'h8000, 16'h0001, 16'h4000, 16'hC000};
	logic [15:0] vb [3] = '{16'hFFFF, 16'hFFFE, 16'h7FFF};
	logic [15:0] vx [3] = '{16'hFFFD, 16'h8000, 16'h0010};
	logic [3:0] nv [3] = '{4'h3, 4'h0, 4'hF};

	always #5 clk_i = ~clk_i;

	bsx_unit bsx_unit_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .issue_i(iss),
		.busy_o(busy_o), .res_o(res_o), .mem_o(mem_o), .mem_ack_i(mem_ack),
		.mem_rdata_i(rdata), .switch_i(sw), .ovf_set_i(ovf_set), .pc_o(pc_o),
		.ovf_o(ovf_o), .prot_o(prot_o), .ptr_b_o(ptr_b_o));
	bsx_core_mem bsx_core_mem_i (.clk_i(clk_i), .mem_i(mem_o), .lat_i(lat),
		.ack_o(mem_ack), .rdata_o(rdata));

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Classic single cycle; ack is looked at mid-cycle to avoid edge races
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		// Ack seen mid-cycle still stands at the next rising edge
		@(negedge clk_i);
		while (wb_ack_o !== 1'b1) begin
			@(negedge clk_i);
		end
		rd = wb_dat_o;
		@(posedge clk_i);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Offer one instruction, count cycles up to the done pulse
	task automatic run(input logic [15:0] ins, e, a, b, x, input logic [2:0] f);
		@(posedge clk_i);
		iss <= {1'b1, ins, e, a, b, x, f};
		@(posedge clk_i);
		iss.valid <= 1'b0;
		ncyc = 1;
		@(negedge clk_i);
		while (res_o.done !== 1'b1) begin
			@(negedge clk_i);
			ncyc++;
		end
		got = res_o;
	endtask
	task automatic go(input logic [14:0] p);
		run(16'h9000, {1'b0, p}, 16'h0000, 16'h0000, 16'h0000, 3'b000);
	endtask
	function automatic int adv(input logic [5:0] op, input logic [15:0] a);
		case (op)
			bsx_pkg::AUG_ZERO: adv = (a == 16'h0000) ? 2 : 1;
			bsx_pkg::AUG_NEG: adv = a[15] ? 2 : 1;
			bsx_pkg::AUG_POS: adv = a[15] ? 1 : 2;
			bsx_pkg::AUG_NORM: adv = (a[14] != a[15]) ? 2 : 1;
			default: adv = a[15] ? 1 : ((a == 16'h0000) ? 2 : 3);
		endcase
	endfunction
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Scenarios need well under a thousand cycles
	initial begin
		#100000;
		err_total++;
		wrap_up();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{cyc, stb, we, ovf_set, adr, dat, lat} = '0;
		iss = '0;
		sw = 16'h0020;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		go(15'h0123);
		chk("jump_pc", 32'h0123, {17'h0, pc_o});
		chk("jump_cycles", 32'h1, ncyc);
		for (i = 0; i < 5; i++) begin
			for (j = 0; j < 5; j++) begin
				go(15'h0100);
				run({10'h000, ops[i]}, 16'h0000, av[j], 16'h0000, 16'h0000, 3'b000);
				chk("skip_pc", 32'h100 + adv(ops[i], av[j]), {17'h0, pc_o});
				chk("skip_cycles", 32'h1, ncyc);
			end
		end
		for (i = 0; i < 3; i++) begin
			go(15'h0100);
			run({10'h000, bsx_pkg::AUG_BUMPB}, 16'h0, 16'h0, vb[i], 16'h0, 3'b0);
			s = vb[i] + 16'h0001;
			chk("b_value", {16'h0, s}, {16'h0, got.b});
			chk("b_pc", s[15] ? 32'h101 : 32'h102, {17'h0, pc_o});
			go(15'h0100);
			run({6'h00, nv[i], bsx_pkg::AUG_BUMPX}, 16'h0, 16'h0, 16'h0, vx[i],
				3'b0);
			s = vx[i] + {12'h000, nv[i]};
			chk("x_pc", s[15] ? 32'h101 : 32'h102, {17'h0, pc_o});
			chk("x_cycles", s[15] ? 32'h1 : 32'h2, ncyc);
			chk("x_write", {31'h0, nv[i] != 4'h0}, {31'h0, got.x_we});
			if (nv[i] != 4'h0) begin
				chk("x_value", {16'h0, s}, {16'h0, got.x});
			end
		end
		run({4'hB, bsx_pkg::SENSE_AUG, 4'h5}, 16'h0, 16'h0, 16'h0, 16'h0, 3'b0);
		chk("switch_set_pc", 32'h103, {17'h0, pc_o});
		run({4'hB, bsx_pkg::SENSE_AUG, 4'h6}, 16'h0, 16'h0, 16'h0, 16'h0, 3'b0);
		chk("switch_clear_pc", 32'h105, {17'h0, pc_o});
		// Set and clear together: set wins, command bits read back as zero
		wb(1'b1, bsx_pkg::REG_CTRL, 32'h0000_000E);
		wb(1'b0, bsx_pkg::REG_CTRL, 32'h0);
		chk("ctrl_read", 32'h0000_0002, rd);
		wb(1'b0, bsx_pkg::REG_STATUS, 32'h0);
		chk("status_read", 32'h0000_0001, rd);
		wb(1'b0, 4'hC, 32'h0);
		chk("unmapped_read", 32'h0, rd);
		wb(1'b1, bsx_pkg::REG_PC, 32'h0000_0155);
		chk("pc_write", 32'h0155, {17'h0, pc_o});
		run(16'h0028, 16'h0, 16'h0, 16'h0, 16'h0, 3'b0);
		chk("ptr_b_pc", 32'h0157, {17'h0, pc_o});
		wb(1'b1, bsx_pkg::REG_CTRL, 32'h0000_0001);
		run(16'h0028, 16'h0, 16'h0, 16'h0, 16'h0, 3'b0);
		chk("ptr_x_pc", 32'h0158, {17'h0, pc_o});
		run(16'h0015, 16'h0, 16'h0, 16'h0, 16'h0, 3'b0);
		chk("ovf_set_pc", 32'h0159, {17'h0, pc_o});
		chk("ovf_cleared", 32'h0, {31'h0, ovf_o});
		run(16'h0015, 16'h0, 16'h0, 16'h0, 16'h0, 3'b0);
		chk("ovf_clear_pc", 32'h015B, {17'h0, pc_o});
		@(posedge clk_i);
		ovf_set <= 1'b1;
		@(posedge clk_i);
		ovf_set <= 1'b0;
		@(negedge clk_i);
		chk("ovf_pulse", 32'h1, {31'h0, ovf_o});
		// Memory group with a prompt and then a slow memory
		for (lt = 0; lt < 3; lt += 2) begin
			lat <= lt[3:0];
			go(15'h0100);
			run(16'hA000, 16'h0020, 16'h0, 16'h0, 16'h0, 3'b000);
			chk("save_word", 32'h0101, {16'h0, bsx_core_mem_i.mem[32]});
			chk("save_pc", 32'h0021, {17'h0, pc_o});
			chk("save_cycles", 2 + lt, ncyc);
			run(16'hA000, 16'h0020, 16'h0, 16'h0, 16'h0, 3'b010);
			chk("irq_word", 32'h0021, {16'h0, bsx_core_mem_i.mem[32]});
			bsx_core_mem_i.mem[48] = 16'hFFFF;
			run(16'hC000, 16'h0030, 16'h0, 16'h0, 16'h0, 3'b000);
			chk("bump_word", 32'h0, {16'h0, bsx_core_mem_i.mem[48]});
			chk("bump_pc", 32'h0023, {17'h0, pc_o});
			chk("bump_cycles", 3 + 2 * lt, ncyc);
			run(16'hC000, 16'h0030, 16'h0, 16'h0, 16'h0, 3'b000);
			chk("bump_pc2", 32'h0024, {17'h0, pc_o});
			bsx_core_mem_i.mem[49] = 16'h0005;
			for (i = 0; i < 3; i++) begin
				go(15'h0100);
				// A of 5, -32763 and 6 against 5: equal, less, greater
				run(16'hD000, 16'h0031, av[i] + 16'h0005, 16'h0, 16'h0, 3'b0);
				s = (i == 0) ? 16'h0102 : ((i == 1) ? 16'h0101 : 16'h0103);
				chk("cmp_pc", {16'h0, s}, {17'h0, pc_o});
				chk("cmp_cycles", 3 + lt, ncyc);
				chk("cmp_mem", 32'h5, {16'h0, bsx_core_mem_i.mem[49]});
			end
			go(15'h0100);
			bsx_core_mem_i.mem[257 & 255] = 16'h8456;
			run(16'h001E, 16'h0, 16'h0, 16'h0, 16'h0, 3'b001);
			chk("long_pc", 32'h0456, {17'h0, pc_o});
			chk("long_cycles", 2 + lt, ncyc);
			chk("long_prot", 32'h1, {31'h0, prot_o});
			run(16'hA000, 16'h0040, 16'h0, 16'h0, 16'h0, 3'b110);
			chk("irq_prot_word", 32'h8456, {16'h0, bsx_core_mem_i.mem[64]});
			run(16'h9000, 16'h7FFF, 16'h0, 16'h0, 16'h0, 3'b101);
			chk("exit_pc", 32'h3FFF, {17'h0, pc_o});
			chk("exit_prot", 32'h0, {31'h0, prot_o});
		end
		wrap_up();
	end
endmodule
